// [hw/smcs_map.vh]
// Register map, field positions and reset values of the serial unit.
// Assumes an 8-bit register port with byte addresses 0 to 7.
`ifndef SMCS_MAP_VH
`define SMCS_MAP_VH

// ************************************************************
// Register addresses
// ************************************************************
`define SMCS_A_MODE 3'h0
`define SMCS_A_CTRL 3'h1
`define SMCS_A_BAUD 3'h2
`define SMCS_A_TXD 3'h3
`define SMCS_A_RXD 3'h4
`define SMCS_A_STAT 3'h5
`define SMCS_A_MASK 3'h6

// ************************************************************
// Mode register fields
// ************************************************************
`define SMCS_M_COMM 7
`define SMCS_M_CHR 6
`define SMCS_M_PE 5
`define SMCS_M_ODD 4
`define SMCS_M_STOP 3
`define SMCS_M_MP 2

// ************************************************************
// Control register fields
// ************************************************************
`define SMCS_C_TE 5
`define SMCS_C_RE 4
`define SMCS_C_TXMPB 3
`define SMCS_C_CKS 1:0
`define SMCS_CKS_INT 2'h0
`define SMCS_CKS_OUT 2'h1
`define SMCS_CKS_EXT 2'h2

// ************************************************************
// Status bits, mask has the same layout for bits 0 to 5 (no MPB bit)
// ************************************************************
`define SMCS_S_RXF 0
`define SMCS_S_TXE 1
`define SMCS_S_OVR 2
`define SMCS_S_FRM 3
`define SMCS_S_PAR 4
`define SMCS_S_BRK 5
`define SMCS_S_MPB 6

// ************************************************************
// Reset values and counts
// ************************************************************
`define SMCS_RST_BYTE 8'h00
`define SMCS_RST_BAUD 8'h0F
`define SMCS_RST_FRAME 12'hFFF
`define SMCS_FRAME_W 4'hC
`define SMCS_SAMPLE_PT 4'h7
`define SMCS_SUB_LAST 4'hF
`define SMCS_SYNC_BITS 4'h8

`endif

// [hw/smcs_serial.v]
// Serial unit with asynchronous and clocked synchronous modes, frame
// format selection and clock source selection.
// Assumes rxd_in and sck_in are already synchronous to clock_in.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "smcs_map.vh"

// Notes on behaviour
// - Mode bit 7 picks asynchronous per-character or clocked synchronous.
// - Mode bit plus control bits 1:0 choose the shift clock source.
// - Asynchronous characters carry five, seven or eight data bits.
// - Async frames add optional parity or multiprocessor bit, 1-2 stops.
// - Multiprocessor off: length bit picks 8 or 7 bits; parity optional.
// - Multiprocessor alone adds that bit; with parity gives five data bits.
// - Synchronous mode moves eight bits only; format bits ignored.
// - Asynchronous receive flags framing, parity, overrun and break.
// - Synchronous receive flags only overrun.
// - Async internal clock uses divider; 01 drives bit-rate clock out.
// - Synchronous internal clock uses divider and drives the clock pin.
// - Synchronous external clock shifts from the clock pin input.
// - Low start, data LSB first, optional extra bit, high stops; idle high.
// - Receiver syncs on start falling edge; samples on eighth of sixteen.
module smcs_serial (
  // Clock and reset
  input wire clock_in,
  input wire rst_in,
  // Register port
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  output wire irq_out,
  // Serial line
  input wire rxd_in,
  output reg txd_out,
  input wire sck_in,
  output reg sck_out,
  output wire sck_oe_out
);

  // ************************************************************
  // Frame format decode
  // ************************************************************
  function [3:0] f_nbits;
    input [7:0] m;
    begin
      if (m[`SMCS_M_COMM])
        f_nbits = `SMCS_SYNC_BITS;
      else if (m[`SMCS_M_MP] & m[`SMCS_M_PE])
        f_nbits = 4'h5;
      else if (m[`SMCS_M_CHR])
        f_nbits = 4'h7;
      else
        f_nbits = 4'h8;
    end
  endfunction

  // Parity only when not paired with MP, except the 7-bit row giving 5+P
  function f_par;
    input [7:0] m;
    begin
      f_par = ~m[`SMCS_M_COMM] & m[`SMCS_M_PE] &
        (~m[`SMCS_M_MP] | m[`SMCS_M_CHR]);
    end
  endfunction

  function f_mpb;
    input [7:0] m;
    begin
      f_mpb = ~m[`SMCS_M_COMM] & m[`SMCS_M_MP] & ~m[`SMCS_M_PE];
    end
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  reg [7:0] mode_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] baud_reg;
  reg [7:0] txbuf_reg;
  reg txfull_reg;
  reg [7:0] rxbuf_reg;
  reg rxmpb_reg;
  reg [5:0] stat_reg;
  reg [5:0] mask_reg;
  reg [5:0] stat_next;
  reg [5:0] ev;
  wire comm = mode_reg[`SMCS_M_COMM];
  wire [1:0] cks = ctrl_reg[`SMCS_C_CKS];
  wire te = ctrl_reg[`SMCS_C_TE];
  wire re = ctrl_reg[`SMCS_C_RE];
  wire ext_clk = (cks == `SMCS_CKS_EXT);
  wire [3:0] nbits = f_nbits(mode_reg);
  wire xbit = f_par(mode_reg) | f_mpb(mode_reg);
  wire [3:0] nstop = mode_reg[`SMCS_M_STOP] ? 4'h2 : 4'h1;
  wire wr_stat = wr_in & (addr_in == `SMCS_A_STAT);

  // ************************************************************
  // Clock selection
  // ************************************************************
  reg [7:0] div_cnt_reg;
  reg sck_prev_reg;
  reg [3:0] bclk_reg;
  reg sclk_reg;
  wire div_tick = (div_cnt_reg == 8'h00);
  wire sck_rise = sck_in & ~sck_prev_reg;
  wire sck_fall = ~sck_in & sck_prev_reg;
  // Divider is left idle with an external clock to save toggling
  wire use_div = ~ext_clk;
  // External async clock: every pin rising edge is one 16x tick
  wire tick16 = ext_clk ? sck_rise : div_tick;
  reg sync_act_reg;
  // Internal sync clock toggles once per divider tick: idle high
  wire s_shift = ext_clk ? sck_fall :
    (div_tick & sclk_reg & sync_act_reg);
  wire s_sample = ext_clk ? sck_rise :
    (div_tick & ~sclk_reg & sync_act_reg);

  // Pin is driven only in the defined output settings
  assign sck_oe_out = comm ? (cks == `SMCS_CKS_INT) :
    (cks == `SMCS_CKS_OUT);

  always @(posedge clock_in) begin
    if (rst_in) begin
      div_cnt_reg <= `SMCS_RST_BYTE;
      sck_prev_reg <= 1'b1;
      bclk_reg <= 4'h0;
      sclk_reg <= 1'b1;
      sck_out <= 1'b1;
    end else begin
      sck_prev_reg <= sck_in;
      if (!use_div || div_tick)
        div_cnt_reg <= baud_reg;
      else
        div_cnt_reg <= div_cnt_reg - 8'h01;
      if (tick16)
        bclk_reg <= bclk_reg + 4'h1;
      if (!sync_act_reg)
        sclk_reg <= 1'b1;
      else if (div_tick)
        sclk_reg <= ~sclk_reg;
      // Async bit clock is one sixteenth of the tick rate
      sck_out <= comm ? sclk_reg : ~bclk_reg[3];
    end
  end

  // ************************************************************
  // Transmitter
  // ************************************************************
  reg tx_busy_reg;
  reg [11:0] tx_frame_reg;
  reg [3:0] tx_left_reg;
  reg [3:0] tx_sub_reg;
  reg [3:0] s_cnt_reg;
  wire tx_load = te & txfull_reg;
  // Without an outside clock a transfer only runs when data is queued
  wire sync_start = comm & ~sync_act_reg &
    (tx_load | (re & ext_clk));
  wire [11:0] tx_data = {4'h0, txbuf_reg} &
    ~(`SMCS_RST_FRAME << nbits);
  wire tx_xval = f_mpb(mode_reg) ? ctrl_reg[`SMCS_C_TXMPB] :
    (^tx_data ^ mode_reg[`SMCS_M_ODD]);
  wire [3:0] tx_len = 4'h1 + nbits + {3'h0, xbit} + nstop;
  // Start low, data LSB first, extra bit, stops and fill high
  wire [11:0] tx_build = (tx_data << 1) |
    ({11'h000, tx_xval & xbit} << (nbits + 4'h1)) |
    (`SMCS_RST_FRAME << (nbits + 4'h1 + {3'h0, xbit}));
  wire tx_start_a = ~comm & te & txfull_reg & ~tx_busy_reg;

  always @(posedge clock_in) begin
    if (rst_in) begin
      tx_busy_reg <= 1'b0;
      tx_frame_reg <= `SMCS_RST_FRAME;
      tx_left_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
      txd_out <= 1'b1;
    end else begin
      if (tx_start_a) begin
        tx_busy_reg <= 1'b1;
        tx_frame_reg <= tx_build;
        tx_left_reg <= tx_len;
        tx_sub_reg <= 4'h0;
      end else if (sync_start) begin
        tx_frame_reg <= tx_load ? {4'hF, txbuf_reg} : `SMCS_RST_FRAME;
      end else if (tx_busy_reg && tick16) begin
        tx_sub_reg <= tx_sub_reg + 4'h1;
        if (tx_sub_reg == `SMCS_SUB_LAST) begin
          tx_frame_reg <= {1'b1, tx_frame_reg[11:1]};
          tx_left_reg <= tx_left_reg - 4'h1;
          if (tx_left_reg == 4'h1)
            tx_busy_reg <= 1'b0;
        end
      end else if (sync_act_reg && s_shift && s_cnt_reg != 4'h0) begin
        tx_frame_reg <= {1'b1, tx_frame_reg[11:1]};
      end
      txd_out <= (tx_busy_reg | sync_act_reg) ? tx_frame_reg[0] : 1'b1;
    end
  end

  // ************************************************************
  // Synchronous shifter
  // ************************************************************
  wire s_done = sync_act_reg & s_sample &
    (s_cnt_reg == `SMCS_SYNC_BITS - 4'h1);

  always @(posedge clock_in) begin
    if (rst_in) begin
      sync_act_reg <= 1'b0;
      s_cnt_reg <= 4'h0;
    end else if (!comm) begin
      sync_act_reg <= 1'b0;
    end else if (sync_start) begin
      sync_act_reg <= 1'b1;
      s_cnt_reg <= 4'h0;
    end else if (sync_act_reg && s_sample) begin
      s_cnt_reg <= s_cnt_reg + 4'h1;
      if (s_done)
        sync_act_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Receiver
  // ************************************************************
  reg rx_busy_reg;
  reg [3:0] rx_sub_reg;
  reg [3:0] rx_cnt_reg;
  reg [11:0] rx_frame_reg;
  reg rxd_prev_reg;
  wire [11:0] rx_word = {rxd_in, rx_frame_reg[11:1]};
  wire [3:0] rx_len = 4'h2 + nbits + {3'h0, xbit}; // first stop only
  wire [11:0] rx_al = rx_word >> (`SMCS_FRAME_W - rx_len);
  wire [11:0] rx_dat = (rx_al >> 1) & ~(`SMCS_RST_FRAME << nbits);
  wire rx_xv = rx_al[nbits + 4'h1];
  wire rx_stop = rx_al[nbits + 4'h1 + {3'h0, xbit}];
  wire rx_smp = rx_busy_reg & tick16 & (rx_sub_reg == `SMCS_SAMPLE_PT);
  wire rx_false = rx_smp & (rx_cnt_reg == 4'h0) & rxd_in;
  wire rx_end = rx_smp & ~rx_false & (rx_cnt_reg + 4'h1 == rx_len);
  wire s_rx_end = s_done & re;
  wire perr = f_par(mode_reg) &
    (^rx_dat[7:0] ^ rx_xv ^ mode_reg[`SMCS_M_ODD]);

  always @(posedge clock_in) begin
    if (rst_in) begin
      rx_busy_reg <= 1'b0;
      rx_sub_reg <= 4'h0;
      rx_cnt_reg <= 4'h0;
      rx_frame_reg <= `SMCS_RST_FRAME;
      rxd_prev_reg <= 1'b1;
    end else begin
      rxd_prev_reg <= rxd_in;
      if (!rx_busy_reg) begin
        // Start bit found on the falling line edge
        if (!comm && re && rxd_prev_reg && !rxd_in) begin
          rx_busy_reg <= 1'b1;
          rx_sub_reg <= 4'h0;
          rx_cnt_reg <= 4'h0;
        end
      end else if (tick16) begin
        rx_sub_reg <= rx_sub_reg + 4'h1;
        if (rx_smp) begin
          rx_frame_reg <= rx_word;
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_false || rx_end)
            rx_busy_reg <= 1'b0;
        end
      end
      if (comm && sync_start)
        rx_frame_reg <= `SMCS_RST_FRAME;
      else if (comm && sync_act_reg && s_sample)
        rx_frame_reg <= rx_word;
    end
  end

  // ************************************************************
  // Events and buffers
  // ************************************************************
  always @* begin
    ev = 6'h00;
    if (rx_end || s_rx_end) begin
      // Data held for software is never overwritten
      if (stat_reg[`SMCS_S_RXF])
        ev[`SMCS_S_OVR] = 1'b1;
      else
        ev[`SMCS_S_RXF] = 1'b1;
    end
    if (rx_end) begin
      ev[`SMCS_S_FRM] = ~rx_stop;
      ev[`SMCS_S_PAR] = perr;
      ev[`SMCS_S_BRK] = ~rx_stop & (rx_al == 12'h000);
    end
    if (tx_start_a || (sync_start && tx_load))
      ev[`SMCS_S_TXE] = 1'b1;
    // Set wins over a clear written in the same cycle
    stat_next = (stat_reg & ~(wr_stat ? wdata_in[5:0] : 6'h00)) | ev;
  end

  assign irq_out = |(stat_reg & mask_reg);

  always @(posedge clock_in) begin
    if (rst_in) begin
      mode_reg <= `SMCS_RST_BYTE;
      ctrl_reg <= `SMCS_RST_BYTE;
      baud_reg <= `SMCS_RST_BAUD;
      txbuf_reg <= `SMCS_RST_BYTE;
      txfull_reg <= 1'b0;
      rxbuf_reg <= `SMCS_RST_BYTE;
      rxmpb_reg <= 1'b0;
      stat_reg <= 6'h00;
      mask_reg <= 6'h00;
      rdata_out <= `SMCS_RST_BYTE;
    end else begin
      stat_reg <= stat_next;
      if (wr_in && addr_in == `SMCS_A_MODE)
        mode_reg <= wdata_in;
      if (wr_in && addr_in == `SMCS_A_CTRL)
        ctrl_reg <= wdata_in;
      if (wr_in && addr_in == `SMCS_A_BAUD)
        baud_reg <= wdata_in;
      if (wr_in && addr_in == `SMCS_A_MASK)
        mask_reg <= wdata_in[5:0];
      if (wr_in && addr_in == `SMCS_A_TXD) begin
        txbuf_reg <= wdata_in;
        txfull_reg <= 1'b1;
      end else if (tx_start_a || (sync_start && tx_load)) begin
        txfull_reg <= 1'b0;
      end
      if (ev[`SMCS_S_RXF]) begin
        rxbuf_reg <= comm ? rx_word[11:4] : rx_dat[7:0];
        rxmpb_reg <= f_mpb(mode_reg) & rx_xv;
      end
      rdata_out <= `SMCS_RST_BYTE;
      if (rd_in) begin
        case (addr_in)
          `SMCS_A_MODE: rdata_out <= mode_reg;
          `SMCS_A_CTRL: rdata_out <= ctrl_reg;
          `SMCS_A_BAUD: rdata_out <= baud_reg;
          `SMCS_A_TXD: rdata_out <= txbuf_reg;
          `SMCS_A_RXD: rdata_out <= rxbuf_reg;
          `SMCS_A_STAT: rdata_out <= {1'b0, rxmpb_reg, stat_reg};
          `SMCS_A_MASK: rdata_out <= {2'h0, mask_reg};
          default: rdata_out <= `SMCS_RST_BYTE;
        endcase
      end
    end
  end

endmodule // smcs_serial

// [sim/smcs_partner.sv]
// Far-side model: remote async station and external clock source.
// Assumes txd_in is the unit's transmit line; bit length in clocks.
`timescale 1ns/10ps
module smcs_partner (
  // Clock
  input wire clock_in,
  // Line from the unit and settings
  input wire txd_in,
  input wire [7:0] bit_cyc_in,
  input wire ext_clk_in,
  // Line and clock to the unit, received word
  output reg rxd_out,
  output reg sck_out,
  output reg got_out,
  output reg [8:0] word_out
);
  integer i;
  initial begin
    rxd_out = 1'b1;
    sck_out = 1'b1;
    got_out = 1'b0;
    word_out = 9'h000;
  end
  // Sixteen ticks per bit; parked high when not asked for
  always @(posedge clock_in) begin
    sck_out <= ext_clk_in ? ~sck_out : 1'b1;
  end
  // Receiver: nine samples, data then the stop slot
  always begin
    @(negedge txd_in);
    repeat (bit_cyc_in / 2) @(posedge clock_in);
    for (i = 0; i < 9; i = i + 1) begin
      repeat (bit_cyc_in) @(posedge clock_in);
      word_out[i] <= txd_in;
    end
    got_out <= 1'b1;
    @(posedge clock_in);
    got_out <= 1'b0;
  end
  // Sends start, eight data LSB first, then the given stop level
  task send_frame(input [7:0] d, input stopv);
    integer k;
    reg [9:0] sh;
    begin
      sh = {stopv, d, 1'b0};
      for (k = 0; k < 10; k = k + 1) begin
        rxd_out <= sh[k];
        repeat (16) @(posedge clock_in);
      end
      rxd_out <= 1'b1;
      @(posedge clock_in);
    end
  endtask
endmodule // smcs_partner

// [sim/smcs_serial_checker.sv]
// Port assertions for the serial unit.
// Assumes mode and control are mirrored from the register port.
`timescale 1ns/10ps
`include "smcs_map.vh"
module smcs_serial_checker (
  // Clock and reset
  input wire clock_in,
  input wire rst_in,
  // Register port
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire irq_out,
  // Serial line
  input wire rxd_in,
  input wire txd_out,
  input wire sck_in,
  input wire sck_out,
  input wire sck_oe_out
);
  reg [7:0] mode_reg;
  reg [7:0] ctrl_reg;
  // Shadow copies, so pin checks need no internal probing
  always @(posedge clock_in) begin
    if (rst_in) begin
      mode_reg <= 8'h00;
      ctrl_reg <= 8'h00;
    end else if (wr_in && addr_in == `SMCS_A_MODE) begin
      mode_reg <= wdata_in;
    end else if (wr_in && addr_in == `SMCS_A_CTRL) begin
      ctrl_reg <= wdata_in;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_rdata_idle_zero: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_mode_read_back: assert property (
    rd_in && addr_in == `SMCS_A_MODE |=>
      (rdata_out & 8'hFC) == (mode_reg & 8'hFC))
    else $error("mode register read back wrong");
  a_ctrl_read_back: assert property (
    rd_in && addr_in == `SMCS_A_CTRL |=>
      (rdata_out & 8'h3B) == (ctrl_reg & 8'h3B))
    else $error("control register read back wrong");
  a_pin_left_port: assert property (
    !mode_reg[7] && ctrl_reg[1:0] == 2'h0 |-> !sck_oe_out)
    else $error("clock pin driven in plain port setting");
  a_bit_clock_out: assert property (
    !mode_reg[7] && ctrl_reg[1:0] == 2'h1 |-> sck_oe_out)
    else $error("bit rate clock not driven");
  a_sync_clock_out: assert property (
    mode_reg[7] && ctrl_reg[1:0] == 2'h0 |-> sck_oe_out)
    else $error("sync internal clock not driven");
  a_ext_clock_in: assert property (
    ctrl_reg[1:0] == 2'h2 |-> !sck_oe_out)
    else $error("clock pin driven while external clock chosen");
  a_start_bit_len: assert property (
    !mode_reg[7] && $fell(txd_out) |-> !txd_out [*8])
    else $error("start bit shorter than half a bit");
  c_tx_frame: cover property (!mode_reg[7] && $fell(txd_out));
  c_irq_level: cover property ($rose(irq_out));
  c_sync_shift: cover property (mode_reg[7] && $fell(sck_out));
endmodule // smcs_serial_checker
bind smcs_serial smcs_serial_checker u_chk (.clock_in(clock_in),
  .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
  .rxd_in(rxd_in), .txd_out(txd_out), .sck_in(sck_in),
  .sck_out(sck_out), .sck_oe_out(sck_oe_out));

// [sim/tb_serial_mode_clock_select.sv]
// Self-checking bench: registers, clock pin table, async frames both
// ways, interrupt, sync byte. Assumes the partner and checker exist.
`timescale 1ns/10ps
`include "smcs_map.vh"
module tb_serial_mode_clock_select;
  reg clock_in;
  reg rst_in;
  reg [2:0] addr_in;
  reg [7:0] wdata_in;
  reg wr_in;
  reg rd_in;
  wire [7:0] rdata_out;
  wire irq_out;
  wire rxd_w;
  wire txd_out;
  wire sck_w;
  wire sck_out;
  wire sck_oe_out;
  wire got;
  wire [8:0] got_word;
  reg [7:0] bit_cyc;
  reg ext_en;
  reg rd_d;
  reg [7:0] d;
  reg [7:0] m;
  reg [8:0] e9;
  reg [3:0] e4;
  reg [15:0] e;
  reg sck_p;
  reg txd_p;
  integer lim;
  reg [15:0] rd_q[$];
  reg [8:0] tx_q[$];
  integer err_total;
  integer n_tests;
  integer cyc;
  integer i;
  smcs_serial u_dut (.clock_in(clock_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .rxd_in(rxd_w),
    .txd_out(txd_out), .sck_in(sck_w), .sck_out(sck_out),
    .sck_oe_out(sck_oe_out));
  smcs_partner u_far (.clock_in(clock_in), .txd_in(txd_out),
    .bit_cyc_in(bit_cyc), .ext_clk_in(ext_en), .rxd_out(rxd_w),
    .sck_out(sck_w), .got_out(got), .word_out(got_word));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // ****************************************
  // Bus tasks, compare, close
  // ****************************************
  task check(input string nm, input [8:0] seen, input [8:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] v);
    begin
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, input [7:0] v, input [7:0] msk);
    begin
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      rd_q.push_back({msk, v});
      @(posedge clock_in);
      rd_in <= 1'b0;
    end
  endtask
  task wait_tx;
    integer k;
    begin
      for (k = 0; k < 3000 && tx_q.size() != 0; k = k + 1)
        @(posedge clock_in);
      check("tx pending", tx_q.size(), 9'h000);
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Read answers land one cycle after the strobe
  always @(posedge clock_in) begin
    if (rd_d) begin
      e = rd_q.pop_front();
      check("rdata", {1'b0, rdata_out & e[15:8]}, {1'b0, e[7:0] & e[15:8]});
    end
    rd_d <= rd_in;
    if (got === 1'b1) check("tx word", got_word, tx_q.pop_front());
    cyc = cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_in = 1'b1;
    addr_in = 3'h0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    bit_cyc = 8'h10;
    ext_en = 1'b0;
    rd_d = 1'b0;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    d = $urandom(58804);
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    check("oe at reset", sck_oe_out, 1'b0);
    check("txd idle", txd_out, 1'b1);
    rd(`SMCS_A_MODE, 8'h00, 8'hFF);
    rd(`SMCS_A_BAUD, 8'h0F, 8'hFF);
    rd(3'h7, 8'h00, 8'hFF);
    // Legal mode and clock source rows only; reserved ones are avoided
    for (i = 0; i < 5; i = i + 1) begin
      e4 = 20'hC9430 >> (4 * i);
      wr(`SMCS_A_MODE, {e4[3], 7'h00});
      wr(`SMCS_A_CTRL, {6'h00, e4[2:1]});
      @(posedge clock_in);
      check("clock pin oe", sck_oe_out, e4[0]);
    end
    wr(`SMCS_A_BAUD, 8'h00);
    wr(`SMCS_A_CTRL, 8'h30);
    // Formats 8N1, 5-bit with parity, 7N1, then external clock
    for (i = 0; i < 4; i = i + 1) begin
      d = $urandom;
      case (i)
        1: begin
          m = 8'h64;
          e9 = {3'h7, ^d[4:0], d[4:0]};
        end
        2: begin
          m = 8'h40;
          e9 = {2'h3, d[6:0]};
        end
        default: begin
          m = 8'h00;
          e9 = {1'b1, d};
        end
      endcase
      if (i == 3) begin
        ext_en <= 1'b1;
        bit_cyc <= 8'h20;
        wr(`SMCS_A_CTRL, 8'h32);
      end
      wr(`SMCS_A_MODE, m);
      tx_q.push_back(e9);
      wr(`SMCS_A_TXD, d);
      wait_tx;
    end
    ext_en <= 1'b0;
    bit_cyc <= 8'h10;
    wr(`SMCS_A_CTRL, 8'h30);
    wr(`SMCS_A_STAT, 8'hFF);
    wr(`SMCS_A_MASK, 8'h09);
    d = $urandom | 8'h01;
    u_far.send_frame(d, 1'b1);
    repeat (4) @(posedge clock_in);
    rd(`SMCS_A_STAT, 8'h01, 8'h3D);
    rd(`SMCS_A_RXD, d, 8'hFF);
    check("irq raised", irq_out, 1'b1);
    wr(`SMCS_A_STAT, 8'h01);
    @(posedge clock_in);
    check("irq cleared", irq_out, 1'b0);
    u_far.send_frame(d, 1'b0);
    repeat (4) @(posedge clock_in);
    rd(`SMCS_A_STAT, 8'h08, 8'h08);
    check("irq framing", irq_out, 1'b1);
    wr(`SMCS_A_MASK, 8'h00);
    @(posedge clock_in);
    check("irq masked", irq_out, 1'b0);
    // Bad parity while old data is still held: overrun keeps old byte
    wr(`SMCS_A_MODE, 8'h20);
    m = $urandom;
    u_far.send_frame(m, ~^m);
    repeat (20) @(posedge clock_in);
    rd(`SMCS_A_STAT, 8'h14, 8'h14);
    rd(`SMCS_A_RXD, d, 8'hFF);
    // Sync: format bits set but must be ignored
    wr(`SMCS_A_MODE, 8'hE8);
    wr(`SMCS_A_CTRL, 8'h20);
    d = $urandom;
    wr(`SMCS_A_TXD, d);
    sck_p = 1'b1;
    txd_p = 1'b1;
    i = 0;
    for (lim = 0; lim < 200 && i < 8; lim = lim + 1) begin
      @(posedge clock_in);
      // Pin levels held just before the clock pin rose
      if (sck_out === 1'b1 && sck_p === 1'b0) begin
        e9[i] = txd_p;
        i = i + 1;
      end
      sck_p = sck_out;
      txd_p = txd_out;
    end
    check("sync bits", i, 9'h008);
    check("sync byte", e9[7:0], d);
    repeat (20) @(posedge clock_in);
    check("sck idle", sck_out, 1'b1);
    tally_and_finish;
  end
endmodule // tb_serial_mode_clock_select
